// [hw/rfdma_map.svh]
// register map, field positions, reset values for the register file dma channel
`ifndef RFDMA_MAP_SVH
`define RFDMA_MAP_SVH

// register indices; byte address on the bus is four times the index
`define RFDMA_IDX_CTL        12'hfb0
`define RFDMA_IDX_PPTR       12'hfb1
`define RFDMA_IDX_HNIB       12'hfb2
`define RFDMA_IDX_START      12'hfb3
`define RFDMA_IDX_END        12'hfb4
`define RFDMA_IDX_IRQ_STS    12'hfb5
`define RFDMA_IDX_IRQ_CLR    12'hfb6
`define RFDMA_IDX_IRQ_EN     12'hfb7

// bus geometry
`define RFDMA_ADR_W          14
`define RFDMA_DAT_W          32

// channel_control fields
`define RFDMA_CTL_EN         7
`define RFDMA_CTL_LOOP       6
`define RFDMA_CTL_DIR        5
`define RFDMA_CTL_IE         4
`define RFDMA_CTL_WSEL       3
`define RFDMA_CTL_TRIG_HI    2
`define RFDMA_CTL_TRIG_LO    0

// address_high_nibbles fields
`define RFDMA_HNIB_END_HI    7
`define RFDMA_HNIB_END_LO    4
`define RFDMA_HNIB_START_HI  3
`define RFDMA_HNIB_START_LO  0

// interrupt status bits
`define RFDMA_IRQ_DONE       0

// trigger codes
`define RFDMA_TRIG_RSVD      3'h7
`define RFDMA_TRIG_NUM       7

// peripheral page and reset values
`define RFDMA_PERIPH_PAGE    4'hf
`define RFDMA_RST_BYTE       8'h00
`define RFDMA_RST_ADDR       12'h000

`endif

// [hw/rfdma_pkg.sv]
// types shared by the register file dma channel
package rfdma_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } rfdma_state_t;

    typedef struct packed {
        logic [7:0]   ctl;
        logic [7:0]   pptr;
        logic [7:0]   hnib;
        logic [7:0]   start_lo;
        logic [11:0]  cur;
        logic [7:0]   end_lo;
        logic [7:0]   sts;
        logic [7:0]   ien;
        rfdma_state_t fsm;
        logic         second;
        logic [11:0]  maddr;
        logic [7:0]   mwdata;
        logic         mwe;
        logic         ack;
        logic [7:0]   rdat;
        logic         irq;
    } rfdma_regs_t;

    typedef struct packed {
        logic prev;
        logic pend;
    } rfdma_trig_t;

endpackage

// [hw/rfdma_trig.sv]
// trigger source select and pending request latch
`timescale 1ns/100ps
`default_nettype none
`include "rfdma_map.svh"

module rfdma_trig #(
    parameter int NUM_SRC = `RFDMA_TRIG_NUM
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // request lines from peripherals
    input  wire logic [NUM_SRC-1:0] trig_in,
    // control
    input  wire logic [2:0]         sel,
    input  wire logic               enable,
    input  wire logic               take,
    // pending request
    output logic                    pending
);

    rfdma_pkg::rfdma_trig_t q;
    rfdma_pkg::rfdma_trig_t d;
    logic                   src;
    logic                   rise;

    always_comb begin
        d = q;
        if (sel == `RFDMA_TRIG_RSVD) begin
            src = 1'b0;
        end else begin
            src = trig_in[sel];
        end
        rise   = src & ~q.prev;
        d.prev = src;
        // only armed while enabled; new edge beats take
        d.pend = enable & (rise | (q.pend & ~take));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pending = q.pend;

endmodule
`default_nettype wire

// [hw/rfdma_top.sv]
// register file dma channel with wishbone register slave
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rfdma_map.svh"

module rfdma_top #(
    parameter int NUM_SRC = `RFDMA_TRIG_NUM
) (
    // clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST,
    // wishbone slave
    input  wire logic                    WB_CYC_I,
    input  wire logic                    WB_STB_I,
    input  wire logic                    WB_WE_I,
    input  wire logic [`RFDMA_ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]              WB_SEL_I,
    input  wire logic [`RFDMA_DAT_W-1:0] WB_DAT_I,
    output logic [`RFDMA_DAT_W-1:0]      WB_DAT_O,
    output logic                         WB_ACK_O,
    // peripheral transfer requests
    input  wire logic [NUM_SRC-1:0]      TRIG_REQ,
    // register file / peripheral byte port
    output logic                         MEM_REQ,
    output logic                         MEM_WE,
    output logic [11:0]                  MEM_ADDR,
    output logic [7:0]                   MEM_WDATA,
    input  wire logic [7:0]              MEM_RDATA,
    input  wire logic                    MEM_ACK,
    // interrupt
    output logic                         IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic reg_hit(
        input logic [`RFDMA_ADR_W-1:0] adr,
        input logic [11:0]             idx
    );
        reg_hit = (adr[`RFDMA_ADR_W-1:2] == idx);
    endfunction

    // peripheral byte address on page F
    function automatic logic [11:0] periph_addr(
        input logic [7:0] ptr,
        input logic       second
    );
        logic [7:0] low;
        low         = ptr + {7'h00, second};
        periph_addr = {`RFDMA_PERIPH_PAGE, low};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    rfdma_pkg::rfdma_regs_t q;
    rfdma_pkg::rfdma_regs_t d;

    logic        pending;
    logic        take;
    logic        bus_req;
    logic        bus_wr;
    logic        dir_rev;
    logic        last_byte;
    logic        done_set;
    logic [7:0]  sts_clr;
    logic [7:0]  wbyte;
    logic [11:0] end_full;
    logic [11:0] start_full;
    logic [11:0] cur_next;

    ////////////////////////////////////////////////////////////////////////////
    // trigger selection

    rfdma_trig #(
        .NUM_SRC (NUM_SRC)
    ) u_trig (
        .clk     (CLK),
        .rst     (RST),
        .trig_in (TRIG_REQ),
        .sel     (q.ctl[`RFDMA_CTL_TRIG_HI:`RFDMA_CTL_TRIG_LO]),
        .enable  (q.ctl[`RFDMA_CTL_EN]),
        .take    (take),
        .pending (pending)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d         = q;
        take      = 1'b0;
        done_set  = 1'b0;
        last_byte = 1'b0;
        sts_clr   = 8'h00;

        bus_req = WB_CYC_I & WB_STB_I;
        // writes land on the acknowledging edge only
        bus_wr  = bus_req & WB_WE_I & q.ack & WB_SEL_I[0];
        wbyte   = WB_DAT_I[7:0];
        dir_rev = q.ctl[`RFDMA_CTL_DIR];

        // end address from its low byte and its high nibble
        end_full   = {q.hnib[`RFDMA_HNIB_END_HI:`RFDMA_HNIB_END_LO], q.end_lo};
        // start address rebuilt from shared nibble and start low byte
        start_full = {q.hnib[`RFDMA_HNIB_START_HI:`RFDMA_HNIB_START_LO], q.start_lo};
        // current steps by one per byte moved
        cur_next   = q.cur + 12'h001;

        ////////////////////////////////////////////////////////////////////////
        // mover

        case (q.fsm)
            rfdma_pkg::ST_IDLE: begin
                d.mwe = 1'b0;
                // serve a request only while enabled
                if (q.ctl[`RFDMA_CTL_EN] && pending) begin
                    take     = 1'b1;
                    d.second = 1'b0;
                    d.fsm    = rfdma_pkg::ST_READ;
                    if (dir_rev) begin
                        d.maddr = periph_addr(q.pptr, 1'b0);
                    end else begin
                        d.maddr = q.cur;
                    end
                end
            end

            rfdma_pkg::ST_READ: begin
                if (MEM_ACK) begin
                    d.mwdata = MEM_RDATA;
                    d.mwe    = 1'b1;
                    d.fsm    = rfdma_pkg::ST_WRITE;
                    // write side is the opposite space
                    if (dir_rev) begin
                        d.maddr = q.cur;
                    end else begin
                        d.maddr = periph_addr(q.pptr, q.second);
                    end
                end
            end

            rfdma_pkg::ST_WRITE: begin
                if (MEM_ACK) begin
                    d.mwe = 1'b0;
                    d.cur = cur_next;
                    // completion when current equals end address
                    last_byte = (q.cur == end_full);
                    if (last_byte) begin
                        d.fsm = rfdma_pkg::ST_IDLE;
                        // event only with interrupt enable set
                        done_set = q.ctl[`RFDMA_CTL_IE];
                        if (q.ctl[`RFDMA_CTL_LOOP]) begin
                            d.cur = start_full;
                        end else begin
                            d.ctl[`RFDMA_CTL_EN] = 1'b0;
                        end
                    end else if (q.ctl[`RFDMA_CTL_WSEL] && !q.second) begin
                        // word mode fetches a second byte
                        d.second = 1'b1;
                        d.fsm    = rfdma_pkg::ST_READ;
                        if (dir_rev) begin
                            d.maddr = periph_addr(q.pptr, 1'b1);
                        end else begin
                            d.maddr = cur_next;
                        end
                    end else begin
                        d.fsm = rfdma_pkg::ST_IDLE;
                    end
                end
            end

            default: begin
                d.fsm = rfdma_pkg::ST_IDLE;
                d.mwe = 1'b0;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        // register writes; software wins over the mover on the same cycle, except on the done status bit

        if (bus_wr) begin
            // all five channel registers are writable
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_CTL)) begin
                d.ctl = wbyte;
            end
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_PPTR)) begin
                d.pptr = wbyte;
            end
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_HNIB)) begin
                d.hnib = wbyte;
                // start nibble also lands in current
                d.cur[11:8] = wbyte[`RFDMA_HNIB_START_HI:`RFDMA_HNIB_START_LO];
            end
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_START)) begin
                // start low byte and current low byte share one write
                d.start_lo = wbyte;
                d.cur      = {q.hnib[`RFDMA_HNIB_START_HI:`RFDMA_HNIB_START_LO], wbyte};
            end
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_END)) begin
                d.end_lo = wbyte;
            end
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_IRQ_CLR)) begin
                sts_clr = wbyte;
            end
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_IRQ_EN)) begin
                d.ien = wbyte;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // interrupt status: a fresh event beats a clear on the same cycle

        d.sts = q.sts & ~sts_clr;
        if (done_set) begin
            d.sts[`RFDMA_IRQ_DONE] = 1'b1;
        end
        d.irq = |(d.sts & d.ien);

        ////////////////////////////////////////////////////////////////////////
        // bus answer: ack one cycle after the request, dropped the next

        d.ack = bus_req & ~q.ack;
        if (bus_req && !q.ack) begin
            // all five channel registers are readable
            if (reg_hit(WB_ADR_I, `RFDMA_IDX_CTL)) begin
                d.rdat = q.ctl;
            end else if (reg_hit(WB_ADR_I, `RFDMA_IDX_PPTR)) begin
                d.rdat = q.pptr;
            end else if (reg_hit(WB_ADR_I, `RFDMA_IDX_HNIB)) begin
                d.rdat = q.hnib;
            end else if (reg_hit(WB_ADR_I, `RFDMA_IDX_START)) begin
                // reads show the running current address
                d.rdat = q.cur[7:0];
            end else if (reg_hit(WB_ADR_I, `RFDMA_IDX_END)) begin
                d.rdat = q.end_lo;
            end else if (reg_hit(WB_ADR_I, `RFDMA_IDX_IRQ_STS)) begin
                d.rdat = q.sts;
            end else if (reg_hit(WB_ADR_I, `RFDMA_IDX_IRQ_EN)) begin
                d.rdat = q.ien;
            end else begin
                // unmapped and write-only locations read zero
                d.rdat = 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            q.ctl      <= `RFDMA_RST_BYTE;
            q.pptr     <= `RFDMA_RST_BYTE;
            q.hnib     <= `RFDMA_RST_BYTE;
            q.start_lo <= `RFDMA_RST_BYTE;
            q.cur      <= `RFDMA_RST_ADDR;
            q.end_lo   <= `RFDMA_RST_BYTE;
            q.sts      <= `RFDMA_RST_BYTE;
            q.ien      <= `RFDMA_RST_BYTE;
            q.fsm      <= rfdma_pkg::ST_IDLE;
            q.second   <= 1'b0;
            q.maddr    <= `RFDMA_RST_ADDR;
            q.mwdata   <= `RFDMA_RST_BYTE;
            q.mwe      <= 1'b0;
            q.ack      <= 1'b0;
            q.rdat     <= `RFDMA_RST_BYTE;
            q.irq      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign WB_ACK_O  = q.ack;
    assign WB_DAT_O  = {24'h00_0000, q.rdat};
    // request held until the memory side acknowledges
    assign MEM_REQ   = (q.fsm == rfdma_pkg::ST_READ) || (q.fsm == rfdma_pkg::ST_WRITE);
    assign MEM_WE    = q.mwe;
    assign MEM_ADDR  = q.maddr;
    assign MEM_WDATA = q.mwdata;
    assign IRQ       = q.irq;

endmodule
`default_nettype wire

// [dv/rfdma_top_asserts.sv]
// port checker for the register file dma channel
`timescale 1ns/100ps
`default_nettype none
`include "rfdma_map.svh"
module rfdma_top_asserts #(
    parameter int NUM_SRC = `RFDMA_TRIG_NUM
) (
    // clock and reset
    input wire logic                    CLK,
    input wire logic                    RST,
    // register bus
    input wire logic                    WB_CYC_I,
    input wire logic                    WB_STB_I,
    input wire logic [`RFDMA_DAT_W-1:0] WB_DAT_O,
    input wire logic                    WB_ACK_O,
    // byte port and interrupt
    input wire logic                    MEM_REQ,
    input wire logic                    MEM_WE,
    input wire logic [11:0]             MEM_ADDR,
    input wire logic [7:0]              MEM_WDATA,
    input wire logic                    MEM_ACK,
    input wire logic                    IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    property p_ack_next;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus request not answered next cycle");
    property p_ack_once;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_idle;
        !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_dat_hi;
        WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000;
    endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
    // request qualifiers frozen while the far side stalls
    property p_mem_hold;
        MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable({MEM_ADDR, MEM_WE}) && (!MEM_WE || $stable(MEM_WDATA));
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("byte request changed before ack");
    property p_rd_then_wr;
        MEM_REQ && !MEM_WE && MEM_ACK |=> MEM_REQ && MEM_WE;
    endproperty
    a_rd_then_wr: assert property (p_rd_then_wr) else $error("read not followed by write");
    property p_page;
        MEM_REQ && !MEM_WE && MEM_ACK && MEM_ADDR[11:8] != `RFDMA_PERIPH_PAGE |=>
            MEM_ADDR[11:8] == `RFDMA_PERIPH_PAGE;
    endproperty
    a_page: assert property (p_page) else $error("peripheral side not on page f");
    property p_no_wr_wr;
        MEM_REQ && MEM_WE && MEM_ACK |=> !(MEM_REQ && MEM_WE);
    endproperty
    a_no_wr_wr: assert property (p_no_wr_wr) else $error("two writes without a read");
    // registered irq path may lag its cause by up to three edges
    property p_irq_rise;
        $rose(IRQ) |-> $past(MEM_WE && MEM_ACK) || $past(MEM_WE && MEM_ACK, 2) || $past(WB_ACK_O)
            || $past(WB_ACK_O, 2) || $past(WB_ACK_O, 3);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(IRQ) |-> $past(WB_ACK_O) || $past(WB_ACK_O, 2) || $past(WB_ACK_O, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without software");
    c_mem_wr: cover property (MEM_REQ && MEM_WE && MEM_ACK);
    c_irq: cover property ($rose(IRQ));
    c_stall: cover property (MEM_REQ && !MEM_ACK ##1 MEM_REQ && !MEM_ACK);
endmodule
bind rfdma_top rfdma_top_asserts #(.NUM_SRC(NUM_SRC)) u_asserts (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .IRQ(IRQ));
`default_nettype wire

// [dv/rfdma_mem_model.sv]
// register file and peripheral memory seen by the byte port
`timescale 1ns/100ps
`default_nettype none
module rfdma_mem_model (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // latency select
    input wire logic        slow,
    // byte port
    input wire logic        MEM_REQ,
    input wire logic        MEM_WE,
    input wire logic [11:0] MEM_ADDR,
    output logic [7:0]      MEM_RDATA,
    output logic            MEM_ACK
);
    logic [1:0] cnt_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= 2'h0;
            MEM_ACK <= 1'b0;
            MEM_RDATA <= 8'h00;
        end else begin
            MEM_ACK <= 1'b0;
            // data toggles outside the ack cycle so stale bytes never pass
            MEM_RDATA <= ~MEM_RDATA;
            if (MEM_REQ && !MEM_ACK) begin
                if (!slow || cnt_q == 2'h3) begin
                    MEM_ACK <= 1'b1;
                    cnt_q <= 2'h0;
                    if (!MEM_WE) begin
                        MEM_RDATA <= MEM_ADDR[7:0] ^ {2{MEM_ADDR[11:8]}};
                    end
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [dv/rfdma_top_tb.sv]
// self-checking bench for the register file dma channel
`timescale 1ns/100ps
`default_nettype none
`include "rfdma_map.svh"
module rfdma_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [13:0] adr = 14'h0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [6:0]  trig = 7'h00;
    logic        slow = 1'b0;
    logic [31:0] rdat;
    logic        ack, mreq, mwe, mack, irq;
    logic [11:0] maddr;
    logic [7:0]  mwdata, mrdata;
    logic [19:0] exp_q[$];
    logic [31:0] rd_q[$];
    int          bad_count = 0;
    int          total_checks = 0;
    integer      seed = 32'h9435;
    always #2.5 clk = ~clk;
    rfdma_top #(.NUM_SRC(7)) dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .TRIG_REQ(trig),
        .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_RDATA(mrdata),
        .MEM_ACK(mack), .IRQ(irq));
    rfdma_mem_model far (.CLK(clk), .RST(rst), .slow(slow), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(maddr),
        .MEM_RDATA(mrdata), .MEM_ACK(mack));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [11:0] a);
        return a[7:0] ^ {2{a[11:8]}};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (!ack && n < 64);
        if (n >= 64) chk(32'h0000_0000, 32'h0000_0001);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [11:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask
    task rd(input logic [11:0] idx, input logic [7:0] e);
        rd_q.push_back({24'h00_0000, e});
        wb(1'b0, idx, 8'h00);
    endtask
    // pulse request lines, then let the noted transfers drain
    task fire(input logic [6:0] m);
        int n;
        n = 0;
        trig <= m;
        repeat (2) @(posedge clk);
        trig <= 7'h00;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) chk(32'h0000_0000, 32'h0000_0002);
        repeat (8) @(posedge clk);
    endtask
    task chk_irq(input logic e);
        @(posedge clk);
        chk({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (mreq && mwe && mack) begin
            if (exp_q.size() == 0) chk({12'h000, maddr, mwdata}, 32'hffff_ffff);
            else chk({12'h000, maddr, mwdata}, {12'h000, exp_q.pop_front()});
        end
        if (ack && !we) chk(rdat, rd_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial begin
        logic [11:0] s;
        logic [7:0]  p, v;
        int          c;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rd(12'hfb0 + 12'(i), 8'h00);
        for (int i = 0; i < 5; i++) begin
            v = 8'($random(seed)) & (i == 0 ? 8'h7f : 8'hff);
            wr(12'hfb0 + 12'(i), v);
            rd(12'hfb0 + 12'(i), v);
        end
        wr(12'hfb8, 8'h5a);
        rd(12'hfb8, 8'h00);
        wr(`RFDMA_IDX_IRQ_EN, 8'h01);
        // one byte block per trigger code
        for (c = 0; c < 7; c++) begin
            s = {4'h1, 8'($random(seed))};
            p = 8'($random(seed));
            slow <= c[0];
            wr(`RFDMA_IDX_HNIB, {s[11:8], s[11:8]});
            wr(`RFDMA_IDX_START, s[7:0]);
            wr(`RFDMA_IDX_END, s[7:0]);
            wr(`RFDMA_IDX_PPTR, p);
            wr(`RFDMA_IDX_CTL, 8'h90 | 8'(c));
            fire(7'h01 << ((c + 1) % 7));
            exp_q.push_back({4'hf, p, pat(s)});
            fire(7'h01 << c);
            chk_irq(1'b1);
            rd(`RFDMA_IDX_CTL, 8'h10 | 8'(c));
            rd(`RFDMA_IDX_IRQ_STS, 8'h01);
            rd(`RFDMA_IDX_IRQ_CLR, 8'h00);
            wr(`RFDMA_IDX_IRQ_EN, 8'h00);
            chk_irq(1'b0);
            wr(`RFDMA_IDX_IRQ_EN, 8'h01);
            wr(`RFDMA_IDX_IRQ_CLR, 8'h01);
            chk_irq(1'b0);
        end
        // word blocks crossing a low byte wrap, looping, slow far side
        s = 12'h2fe;
        p = 8'($random(seed)) & 8'h7f;
        slow <= 1'b1;
        wr(`RFDMA_IDX_HNIB, 8'h32);
        wr(`RFDMA_IDX_START, 8'hfe);
        wr(`RFDMA_IDX_END, 8'h01);
        wr(`RFDMA_IDX_PPTR, p);
        wr(`RFDMA_IDX_CTL, 8'hed);
        for (int k = 0; k < 6; k++) begin
            exp_q.push_back({s + 12'(k % 4), pat({4'hf, p + 8'(k % 2)})});
            if (k % 2 == 1) fire(7'h20);
        end
        chk_irq(1'b0);
        rd(`RFDMA_IDX_IRQ_STS, 8'h00);
        rd(`RFDMA_IDX_CTL, 8'hed);
        wr(`RFDMA_IDX_CTL, 8'h6d);
        fire(7'h20);
        wr(`RFDMA_IDX_CTL, 8'h87);
        fire(7'h7f);
        summarize();
    end
endmodule
`default_nettype wire
